// ---- design/ext_irq_pkg.sv ----
// Constants, carriers and shared helpers for the extended interrupt priority logic
// Function
// - Bit 5 of extended_priority_one at 0xF3 makes the comparator interrupt high priority.
// - Bit 4 of extended_priority_one makes the counter array interrupt high priority.
// - Bit 3 of extended_priority_one makes the conversion-complete interrupt high priority.
// - Bit 2 of extended_priority_one makes the window-compare interrupt high priority.
// - Bit 1 of extended_priority_one makes the port match interrupt high priority.
// - Bit 0 of extended_priority_one makes the two-wire bus interrupt high priority.
// - Bit 1 of extended_priority_two at 0xF4 makes capsense threshold interrupt high.
// - Bit 0 of extended_priority_two sets capsense done priority; bits 7:2 read-only.
// - Each external input has its own polarity bit in the configuration register.
// - Each external input has its own edge/level bit in the timer control register.
// - Edge bit 1 means edge, 0 level; polarity 1 active high, 0 low.
// - External inputs only sample their selected pins and never drive them.
// - Pending flags sit at bits 1 and 3 of the timer control register.
// - In edge mode the pending flag clears when the CPU vectors to it.
// - In level mode the pending flag reads 1 while the input is active.
// - In level mode the pending flag reads 0 while inactive, nothing latched.
// - Three-bit pin select per input; codes 000..111 pick port 0 pins 0..7.
// - Polarity of the second input is bit 7 of the configuration register.
package ext_irq_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PRIO_ONE = 8'hf3;
	localparam logic [7:0] ADDR_PRIO_TWO = 8'hf4;
	localparam logic [7:0] ADDR_EXT_CFG = 8'he4;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] RST_PRIO_ONE = 6'h00;
	localparam logic [1:0] RST_PRIO_TWO = 2'h0;
	localparam logic [7:0] RST_EXT_CFG = 8'h01;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_A_SEL_LSB = 0;
	localparam int CFG_A_POL = 3;
	localparam int CFG_B_SEL_LSB = 4;
	localparam int CFG_B_POL = 7;
	localparam int TC_A_EDGE = 0;
	localparam int TC_A_PEND = 1;
	localparam int TC_B_EDGE = 2;
	localparam int TC_B_PEND = 3;

	// ----------------------------------------------------------------
	// Source identifiers; lower index wins inside one level
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 10;
	localparam logic [3:0] ID_EXT_A = 4'h0;
	localparam logic [3:0] ID_EXT_B = 4'h1;
	localparam logic [3:0] ID_NONE = 4'hf;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfr_req_t;

	typedef struct packed {
		logic req;
		logic high;
		logic [3:0] id;
	} irq_out_t;

	function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
		logic [3:0] r;
		r = ID_NONE;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

endpackage

// ---- design/ext_irq_detect.sv ----
// Polarity, edge/level detection and pending flag for one external interrupt input
`timescale 1ns/10ps
`default_nettype none
module ext_irq_detect
	import ext_irq_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic pin,
	input wire logic polarity,
	input wire logic edge_mode,
	input wire logic hw_clear,
	input wire logic sw_wr,
	input wire logic sw_val,
	output logic pending
);

	logic active;
	logic prev_active;
	logic rise;

	assign active = polarity ? pin : ~pin;
	assign rise = active & ~prev_active;

	// Reset to active so a pin already asserted at reset gives no false edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prev_active <= 1'b1;
		end else begin
			prev_active <= active;
		end
	end

	// ----------------------------------------------------------------
	// Pending flag; a new edge beats any clear in the same cycle
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pending <= 1'b0;
		end else if (!edge_mode) begin
			pending <= active;
		end else if (rise) begin
			pending <= 1'b1;
		end else if (hw_clear) begin
			pending <= 1'b0;
		end else if (sw_wr) begin
			pending <= sw_val;
		end
	end

	property p_level_follows;
		@(posedge mclk) disable iff (!nrst)
		!edge_mode |=> (pending == $past(active)) || edge_mode;
	endproperty
	a_level_follows: assert property (p_level_follows)
		else $error("level pending does not follow input");

	property p_level_no_latch;
		@(posedge mclk) disable iff (!nrst)
		(!edge_mode && !active) [*2] |-> !pending;
	endproperty
	a_level_no_latch: assert property (p_level_no_latch)
		else $error("level pending latched while inactive");

	property p_edge_sets;
		@(posedge mclk) disable iff (!nrst)
		edge_mode && active && !prev_active |=> pending;
	endproperty
	a_edge_sets: assert property (p_edge_sets)
		else $error("edge into active level did not set pending");

	property p_edge_clears;
		@(posedge mclk) disable iff (!nrst)
		edge_mode && hw_clear && !rise |=> !pending;
	endproperty
	a_edge_clears: assert property (p_edge_clears)
		else $error("vectoring did not clear edge pending");

endmodule
`default_nettype wire

// ---- design/irq_priority_pick.sv ----
// Picks the first pending source of each priority level
`timescale 1ns/10ps
`default_nettype none
module irq_priority_pick
	import ext_irq_pkg::*;
(
	input wire logic [NUM_SRC-1:0] req,
	input wire logic [NUM_SRC-1:0] prio_high,
	output logic found_high,
	output logic found_low,
	output logic [3:0] id_high,
	output logic [3:0] id_low
);

	logic [NUM_SRC-1:0] req_high;
	logic [NUM_SRC-1:0] req_low;

	assign req_high = req & prio_high;
	assign req_low = req & ~prio_high;
	assign found_high = |req_high;
	assign found_low = |req_low;
	assign id_high = first_set(req_high);
	assign id_low = first_set(req_low);

endmodule
`default_nettype wire

// ---- design/ext_irq_priority_logic.sv ----
// Extended priority registers, external interrupt inputs and two-level request arbitration
`timescale 1ns/10ps
`default_nettype none
module ext_irq_priority_logic
	import ext_irq_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire sfr_req_t sfr,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] port0_pins,
	input wire logic [7:0] periph_req,
	input wire logic [1:0] ext_base_prio,
	input wire logic cpu_ack,
	input wire logic cpu_reti,
	output irq_out_t irq_out
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [5:0] extended_priority_one;
	logic [1:0] extended_priority_two;
	logic [7:0] ext_irq_config_reg;
	logic ext_irq_a_edge_mode;
	logic ext_irq_b_edge_mode;
	logic ext_irq_a_pending;
	logic ext_irq_b_pending;
	logic hi_in_service;
	logic lo_in_service;

	logic wr_prio_one;
	logic wr_prio_two;
	logic wr_cfg;
	logic wr_tc;
	logic ext_irq_a_polarity;
	logic ext_irq_b_polarity;
	logic [2:0] ext_irq_a_pin_select;
	logic [2:0] ext_irq_b_pin_select;
	logic pin_a;
	logic pin_b;
	logic taken;
	logic clear_a;
	logic clear_b;

	assign wr_prio_one = sfr.wr && (sfr.addr == ADDR_PRIO_ONE);
	assign wr_prio_two = sfr.wr && (sfr.addr == ADDR_PRIO_TWO);
	assign wr_cfg = sfr.wr && (sfr.addr == ADDR_EXT_CFG);
	assign wr_tc = sfr.wr && (sfr.addr == ADDR_TIMER_CTRL);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			extended_priority_one <= RST_PRIO_ONE;
		end else if (wr_prio_one) begin
			// Bits 7:6 are write-zero reserved and not stored
			extended_priority_one <= sfr.wdata[5:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			extended_priority_two <= RST_PRIO_TWO;
		end else if (wr_prio_two) begin
			extended_priority_two <= sfr.wdata[1:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_irq_config_reg <= RST_EXT_CFG;
		end else if (wr_cfg) begin
			ext_irq_config_reg <= sfr.wdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_irq_a_edge_mode <= 1'b0;
			ext_irq_b_edge_mode <= 1'b0;
		end else if (wr_tc) begin
			ext_irq_a_edge_mode <= sfr.wdata[TC_A_EDGE];
			ext_irq_b_edge_mode <= sfr.wdata[TC_B_EDGE];
		end
	end

	// ----------------------------------------------------------------
	// Pin selection and detection
	// ----------------------------------------------------------------
	assign ext_irq_a_polarity = ext_irq_config_reg[CFG_A_POL];
	assign ext_irq_b_polarity = ext_irq_config_reg[CFG_B_POL];
	assign ext_irq_a_pin_select = ext_irq_config_reg[CFG_A_SEL_LSB +: 3];
	assign ext_irq_b_pin_select = ext_irq_config_reg[CFG_B_SEL_LSB +: 3];
	// Pins are only read, so any crossbar peripheral on them is undisturbed
	assign pin_a = port0_pins[ext_irq_a_pin_select];
	assign pin_b = port0_pins[ext_irq_b_pin_select];

	assign taken = cpu_ack && irq_out.req;
	assign clear_a = taken && (irq_out.id == ID_EXT_A);
	assign clear_b = taken && (irq_out.id == ID_EXT_B);

	ext_irq_detect u_detect_a (
		.mclk(mclk),
		.nrst(nrst),
		.pin(pin_a),
		.polarity(ext_irq_a_polarity),
		.edge_mode(ext_irq_a_edge_mode),
		.hw_clear(clear_a),
		.sw_wr(wr_tc),
		.sw_val(sfr.wdata[TC_A_PEND]),
		.pending(ext_irq_a_pending)
	);

	ext_irq_detect u_detect_b (
		.mclk(mclk),
		.nrst(nrst),
		.pin(pin_b),
		.polarity(ext_irq_b_polarity),
		.edge_mode(ext_irq_b_edge_mode),
		.hw_clear(clear_b),
		.sw_wr(wr_tc),
		.sw_val(sfr.wdata[TC_B_PEND]),
		.pending(ext_irq_b_pending)
	);

	// ----------------------------------------------------------------
	// Register read; unmapped addresses and reserved bits read zero
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata <= RST_RDATA;
		end else if (sfr.rd) begin
			unique case (sfr.addr)
				ADDR_PRIO_ONE: sfr_rdata <= {2'h0, extended_priority_one};
				ADDR_PRIO_TWO: sfr_rdata <= {6'h00, extended_priority_two};
				ADDR_EXT_CFG: sfr_rdata <= ext_irq_config_reg;
				ADDR_TIMER_CTRL: sfr_rdata <= {4'h0, ext_irq_b_pending, ext_irq_b_edge_mode,
					ext_irq_a_pending, ext_irq_a_edge_mode};
				default: sfr_rdata <= RST_RDATA;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] all_req;
	logic [NUM_SRC-1:0] all_prio;
	logic found_high;
	logic found_low;
	logic [3:0] id_high;
	logic [3:0] id_low;

	assign all_req = {periph_req, ext_irq_b_pending, ext_irq_a_pending};
	assign all_prio = {extended_priority_two, extended_priority_one, ext_base_prio};

	irq_priority_pick u_pick (
		.req(all_req),
		.prio_high(all_prio),
		.found_high(found_high),
		.found_low(found_low),
		.id_high(id_high),
		.id_low(id_low)
	);

	// Nesting is two deep at most, so two flags replace a level stack
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hi_in_service <= 1'b0;
			lo_in_service <= 1'b0;
		end else if (taken) begin
			if (irq_out.high) begin
				hi_in_service <= 1'b1;
			end else begin
				lo_in_service <= 1'b1;
			end
		end else if (cpu_reti) begin
			if (hi_in_service) begin
				hi_in_service <= 1'b0;
			end else begin
				lo_in_service <= 1'b0;
			end
		end
	end

	// Request drops the cycle after the ack so a cleared flag is not offered twice
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_out <= '{req: 1'b0, high: 1'b0, id: ID_NONE};
		end else if (taken) begin
			irq_out <= '{req: 1'b0, high: 1'b0, id: ID_NONE};
		end else if (found_high && !hi_in_service) begin
			irq_out <= '{req: 1'b1, high: 1'b1, id: id_high};
		end else if (found_low && !hi_in_service && !lo_in_service) begin
			irq_out <= '{req: 1'b1, high: 1'b0, id: id_low};
		end else begin
			irq_out <= '{req: 1'b0, high: 1'b0, id: ID_NONE};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_high_waiting;
		found_high && !hi_in_service && !taken;
	endsequence

	sequence s_high_ack;
		taken && irq_out.high;
	endsequence

	property p_high_first;
		@(posedge mclk) disable iff (!nrst)
		s_high_waiting |=> irq_out.req && irq_out.high;
	endproperty
	a_high_first: assert property (p_high_first)
		else $error("pending high request not presented first");

	property p_no_high_nest;
		@(posedge mclk) disable iff (!nrst)
		s_high_ack ##1 !cpu_reti [*2] |-> !irq_out.req;
	endproperty
	a_no_high_nest: assert property (p_no_high_nest)
		else $error("request offered during high routine");

	property p_low_blocked;
		@(posedge mclk) disable iff (!nrst)
		irq_out.req && !irq_out.high |-> !$past(lo_in_service) && !$past(hi_in_service);
	endproperty
	a_low_blocked: assert property (p_low_blocked)
		else $error("low request offered while a routine runs");

	property p_prio_one_write;
		@(posedge mclk) disable iff (!nrst)
		wr_prio_one |=> extended_priority_one == $past(sfr.wdata[5:0]);
	endproperty
	a_prio_one_write: assert property (p_prio_one_write)
		else $error("priority one write not stored");

	property p_prio_two_read;
		@(posedge mclk) disable iff (!nrst)
		sfr.rd && sfr.addr == ADDR_PRIO_TWO |=> sfr_rdata[7:2] == 6'h00;
	endproperty
	a_prio_two_read: assert property (p_prio_two_read)
		else $error("reserved priority two bits not zero");

	property p_pend_read;
		@(posedge mclk) disable iff (!nrst)
		sfr.rd && sfr.addr == ADDR_TIMER_CTRL |=>
			sfr_rdata[TC_A_PEND] == $past(ext_irq_a_pending) &&
			sfr_rdata[TC_B_PEND] == $past(ext_irq_b_pending);
	endproperty
	a_pend_read: assert property (p_pend_read)
		else $error("pending flags misplaced in timer control read");

	property p_high_id;
		@(posedge mclk) disable iff (!nrst)
		s_high_waiting |=> irq_out.id == $past(id_high);
	endproperty
	a_high_id: assert property (p_high_id)
		else $error("high request carries the wrong source");

	property p_low_offer;
		@(posedge mclk) disable iff (!nrst)
		found_low && !found_high && !hi_in_service && !lo_in_service && !taken |=>
			irq_out.req && !irq_out.high && irq_out.id == $past(id_low);
	endproperty
	a_low_offer: assert property (p_low_offer)
		else $error("idle low request not offered");

	property p_ack_drops;
		@(posedge mclk) disable iff (!nrst)
		taken |=> !irq_out.req && irq_out.id == ID_NONE;
	endproperty
	a_ack_drops: assert property (p_ack_drops)
		else $error("request still offered after vectoring");

	sequence s_low_ack;
		taken && !irq_out.high;
	endsequence

	// A lost low flag would let a second low routine nest inside the first
	property p_low_open;
		@(posedge mclk) disable iff (!nrst)
		s_low_ack |=> lo_in_service;
	endproperty
	a_low_open: assert property (p_low_open)
		else $error("low routine not marked open");

	property p_prio_two_write;
		@(posedge mclk) disable iff (!nrst)
		wr_prio_two |=> extended_priority_two == $past(sfr.wdata[1:0]);
	endproperty
	a_prio_two_write: assert property (p_prio_two_write)
		else $error("priority two write not stored");

	property p_cfg_write;
		@(posedge mclk) disable iff (!nrst)
		wr_cfg |=> ext_irq_config_reg == $past(sfr.wdata);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("configuration write not stored");

	property p_edge_mode_write;
		@(posedge mclk) disable iff (!nrst)
		wr_tc |=> ext_irq_a_edge_mode == $past(sfr.wdata[TC_A_EDGE]) &&
			ext_irq_b_edge_mode == $past(sfr.wdata[TC_B_EDGE]);
	endproperty
	a_edge_mode_write: assert property (p_edge_mode_write)
		else $error("edge mode bits not stored");

endmodule
`default_nettype wire

// ---- dv/irq_far_side_model.sv ----
// Far side model: CPU core vectoring and returning, plus the port 0 interrupt sources
`timescale 1ns/10ps
`default_nettype none
module irq_far_side_model
	import ext_irq_pkg::*;
(
	input wire logic mclk,
	input wire irq_out_t irq_out,
	output logic cpu_ack,
	output logic cpu_reti,
	output logic [7:0] port0_pins
);
	// ----------------------------------------------------------------
	// Idle state
	// ----------------------------------------------------------------
	// Pins idle high; nothing but this model drives them, as if the crossbar skips them
	initial begin
		cpu_ack = 1'b0;
		cpu_reti = 1'b0;
		port0_pins = 8'hff;
	end

	// ----------------------------------------------------------------
	// Actions
	// ----------------------------------------------------------------
	task automatic drive(input logic [7:0] v);
		@(negedge mclk) port0_pins = v;
	endtask

	task automatic vector();
		@(negedge mclk) cpu_ack = 1'b1;
		@(negedge mclk) cpu_ack = 1'b0;
	endtask

	task automatic ret();
		@(negedge mclk) cpu_reti = 1'b1;
		@(negedge mclk) cpu_reti = 1'b0;
	endtask

	// Level source: stays active until vectored, lets go before the routine returns
	task automatic serve_level(input logic [7:0] mask, input int lag);
		for (int i = 0; i < 16 && irq_out.req !== 1'b1; i++) begin
			@(negedge mclk);
		end
		// A slow core leaves the request waiting a few cycles
		repeat (lag) @(negedge mclk);
		vector();
		port0_pins = port0_pins ^ mask;
	endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the extended interrupt priority logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench
	import ext_irq_pkg::*;
;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	sfr_req_t sfr = '0;
	logic [7:0] sfr_rdata;
	logic [7:0] port0_pins;
	logic [7:0] periph_req = 8'h00;
	logic [1:0] ext_base_prio = 2'h0;
	logic cpu_ack;
	logic cpu_reti;
	irq_out_t irq_out;
	int miscompares = 0;
	int checks_done = 0;

	always #25 mclk = ~mclk;

	ext_irq_priority_logic dut_u (.mclk(mclk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.port0_pins(port0_pins), .periph_req(periph_req), .ext_base_prio(ext_base_prio),
		.cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq_out(irq_out));
	irq_far_side_model cpu_u (.mclk(mclk), .irq_out(irq_out), .cpu_ack(cpu_ack),
		.cpu_reti(cpu_reti), .port0_pins(port0_pins));

	// ----------------------------------------------------------------
	// Register access and expectations
	// ----------------------------------------------------------------
	// Idle cycle between accesses keeps each strobe to one assignment per time step
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(negedge mclk) sfr = {a, d, w, !w};
		@(negedge mclk) sfr = '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, d, 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(a, 8'h00, 1'b0);
		`CHK(sfr_rdata, e)
	endtask

	function automatic logic [7:0] rmask(input logic [7:0] a);
		case (a)
			8'hf3: return 8'h3f;
			8'hf4: return 8'h03;
			8'he4: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] tc(input int k, input logic e, input logic p);
		return {4'h0, p && k == 1, e, p && k == 0, e};
	endfunction

	function automatic logic [3:0] low_id(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				low_id = 4'(i + 2);
			end
		end
	endfunction

	task automatic tally_and_finish();
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] pv;
		logic [2:0] s;
		logic [7:0] addrs[4];
		int k;
		int pin;
		logic pol;
		logic e;
		void'($urandom(32'h46467f5b));
		addrs = '{8'hf3, 8'hf4, 8'he4, 8'h55};
		repeat (5) @(posedge mclk);
		@(negedge mclk) nrst = 1'b1;
		rd(8'hf3, 8'h00);
		rd(8'hf4, 8'h00);
		rd(8'he4, 8'h01);
		rd(8'h88, 8'h00);
		foreach (addrs[j]) begin
			v = 8'($urandom) | 8'hc0;
			wr(addrs[j], v);
			rd(addrs[j], v & rmask(addrs[j]));
		end
		wr(8'he4, 8'h01);
		wr(8'h88, 8'hf0);
		rd(8'h88, 8'h00);
		// One source high at a time, among random low competitors
		for (int i = 0; i < 8; i++) begin
			pv = 8'(1 << i);
			wr(8'hf3, {2'b00, pv[5:0]});
			wr(8'hf4, {6'h00, pv[7:6]});
			@(negedge mclk) periph_req = 8'($urandom) | pv;
			repeat (2) @(negedge mclk);
			`CHK(irq_out, {1'b1, 1'b1, 4'(i + 2)})
		end
		wr(8'hf4, 8'h00);
		repeat (2) @(negedge mclk);
		`CHK(irq_out, {1'b1, 1'b0, low_id(periph_req)})
		// Low routine, high preempts it, nothing preempts high
		@(negedge mclk) periph_req = 8'h01;
		repeat (2) @(negedge mclk);
		`CHK(irq_out, {1'b1, 1'b0, 4'h2})
		cpu_u.vector();
		wr(8'hf3, 8'h02);
		`CHK(irq_out.req, 1'b0)
		@(negedge mclk) periph_req = 8'h03;
		repeat (2) @(negedge mclk);
		`CHK(irq_out, {1'b1, 1'b1, 4'h3})
		cpu_u.vector();
		repeat (2) @(negedge mclk);
		`CHK(irq_out.req, 1'b0)
		cpu_u.ret();
		repeat (2) @(negedge mclk);
		`CHK(irq_out, {1'b1, 1'b1, 4'h3})
		cpu_u.vector();
		@(negedge mclk) periph_req = 8'h00;
		cpu_u.ret();
		cpu_u.ret();
		// Every pin code, both inputs, both polarities, edge and level
		for (int n = 0; n < 16; n++) begin
			k = n % 2;
			pol = n[1];
			e = n[2];
			s = 3'(n >> 1);
			pin = s;
			cpu_u.drive(~{8{pol}});
			@(negedge mclk) ext_base_prio = 2'($urandom);
			wr(8'he4, k ? {pol, s, pol, ~s} : {pol, ~s, pol, s});
			wr(8'h88, tc(k, e, 1'b0));
			cpu_u.drive(port0_pins ^ (8'h01 << pin));
			repeat (2) @(negedge mclk);
			`CHK(irq_out, {1'b1, ext_base_prio[k], 4'(k)})
			rd(8'h88, tc(k, e, 1'b1));
			if (e) begin
				cpu_u.vector();
				rd(8'h88, tc(k, e, 1'b0));
				// Software may set and clear an edge flag; the open routine masks it
				wr(8'h88, tc(k, e, 1'b1));
				rd(8'h88, tc(k, e, 1'b1));
				wr(8'h88, tc(k, e, 1'b0));
				cpu_u.drive(port0_pins ^ (8'h01 << pin));
			end else begin
				cpu_u.serve_level(8'h01 << pin, int'($urandom % 4));
				repeat (2) @(negedge mclk);
				rd(8'h88, tc(k, e, 1'b0));
			end
			cpu_u.ret();
			// Wait past the return so a stuck flag would be offered again
			repeat (2) @(negedge mclk);
			`CHK(irq_out.req, 1'b0)
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
